// >>> hw/reset_strap_config.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - strap 62 picks AD16 or AD17 select
// - remap ROM top 8K only with VGA off
// - interrupt pin reads 01h low, 00h high
// - advertise strap never blocks interrupt line
// - strap 58 high disables VGA portion
// - strap 57 picks feature or multimedia connector
// - strap 55 high enters test mode
// - prefetch strap sets BAR bit 3
// - off strap silences bus and select
// - three-bit memory type encoding
// - strapped memory type reads back inverted
// - firmware may write memory type
// - strap 47 low tristates both chip selects
// - strap 40 picks package-dependent bus type
// - VCO gain strap remapped to PLL gain
// - strap 37 high means flash BIOS
// - memory module speed straps 31 to 29
// - vendor ID from firmware or straps
// - device ID low byte from straps
// - clock source depends on bus variant
// - reserved straps 28 to 24 ignored
module reset_strap_config
   import strap_cfg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        bus_reset_n,
   input  wire logic [63:0] memory_data_bus_i,
   input  wire logic        clock_source_strap_pin,
   input  wire logic        package_is_bga,
   input  wire logic        irq_request,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             memory_data_bus_oe,
   output logic             idsel_from_ad17,
   output logic             idsel_enable,
   output logic             bus_respond_en,
   output logic             bus_drive_en,
   output logic             rom_remap_en,
   output logic      [7:0]  interrupt_pin_value,
   output logic             irq_line_o,
   output logic             irq_line_oe,
   output logic             vga_disabled,
   output logic             multimedia_connector_mode,
   output logic             legacy_feature_connector_mode,
   output logic             test_mode,
   output logic             bar_prefetchable,
   output logic             controller_disabled,
   output logic      [2:0]  mem_type,
   output logic             mem_access_off,
   output logic      [1:0]  chip_select_oe,
   output logic             bus_is_agp,
   output logic      [1:0]  pll_vco_gain,
   output logic             flash_bios_present,
   output logic      [2:0]  sodimm_speed,
   output logic      [15:0] subsystem_vendor_identifier,
   output logic      [15:0] subsystem_device_identifier,
   output logic             clock_from_pll,
   output logic             straps_latched
);

   function automatic logic [1:0] vco_map(input logic [1:0] s);
      vco_map = {~s[1], s[0]};
   endfunction : vco_map

   function automatic logic agp_of(input logic bga, input logic bt);
      agp_of = bga ? ~bt : bt;
   endfunction : agp_of

   logic [63:0] md_meta_q;
   logic [63:0] md_sync_q;
   logic        rst_meta_q;
   logic        rst_sync_q;
   logic        clk_meta_q;
   logic        clk_sync_q;
   logic        pkg_meta_q;
   logic        pkg_sync_q;
   logic [63:0] capture_q;
   logic [63:0] strap_q;
   logic        clk_strap_q;
   logic        pkg_q;
   phase_e      phase_q;
   phase_e      phase_d;
   logic        latch;
   logic        mt_written_q;
   logic [2:0]  mt_wr_q;
   logic [31:0] status;
   logic [31:0] rd_mux;
   logic        hit;
   logic        wr_en;

   // Pins come from outside this clock; two stages before use
   // Bus reset stages start at the pin's idle level so that a chip reset
   // never looks like a bus reset and latches straps from a cleared bus
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         md_meta_q  <= 64'h0;
         md_sync_q  <= 64'h0;
         rst_meta_q <= 1'b1;
         rst_sync_q <= 1'b1;
         clk_meta_q <= 1'b0;
         clk_sync_q <= 1'b0;
         pkg_meta_q <= 1'b0;
         pkg_sync_q <= 1'b0;
      end else begin
         md_meta_q  <= memory_data_bus_i;
         md_sync_q  <= md_meta_q;
         rst_meta_q <= bus_reset_n;
         rst_sync_q <= rst_meta_q;
         clk_meta_q <= clock_source_strap_pin;
         clk_sync_q <= clk_meta_q;
         pkg_meta_q <= package_is_bga;
         pkg_sync_q <= pkg_meta_q;
      end
   end

   assign latch = (phase_q == ST_SAMPLE) && rst_sync_q;

   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         ST_WAIT:   if (!rst_sync_q) phase_d = ST_SAMPLE;
         ST_SAMPLE: if (rst_sync_q) phase_d = ST_HOLD;
         ST_HOLD:   if (!rst_sync_q) phase_d = ST_SAMPLE;
         default:   phase_d = ST_WAIT;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         phase_q <= ST_WAIT;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Follow the resistors every cycle of bus reset, keep the last
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         capture_q <= STRAP_DEFAULT;
      end else if (phase_q == ST_SAMPLE && !rst_sync_q) begin
         capture_q <= md_sync_q & STRAP_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         strap_q     <= STRAP_DEFAULT;
         clk_strap_q <= 1'b0;
         pkg_q       <= 1'b0;
      end else if (latch) begin
         strap_q     <= capture_q;
         clk_strap_q <= clk_sync_q;
         pkg_q       <= pkg_sync_q;
      end
   end

   // Output only once straps are latched; a few cycles of drive
   // may remain after bus reset falls, hidden by synchroniser delay
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         memory_data_bus_oe <= 1'b0;
      end else begin
         memory_data_bus_oe <= (phase_d == ST_HOLD);
      end
   end

   // Decoded settings, refreshed only at the latch edge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         idsel_from_ad17               <= 1'b0;
         idsel_enable                  <= 1'b1;
         bus_respond_en                <= 1'b1;
         bus_drive_en                  <= 1'b1;
         rom_remap_en                  <= 1'b0;
         interrupt_pin_value           <= INT_PIN_NONE;
         vga_disabled                  <= 1'b0;
         multimedia_connector_mode     <= 1'b1;
         legacy_feature_connector_mode <= 1'b0;
         test_mode                     <= 1'b0;
         bar_prefetchable              <= 1'b0;
         controller_disabled           <= 1'b0;
         chip_select_oe                <= 2'h3;
         bus_is_agp                    <= 1'b0;
         pll_vco_gain                  <= 2'h2;
         flash_bios_present            <= 1'b0;
         sodimm_speed                  <= 3'h0;
         clock_from_pll                <= 1'b0;
         straps_latched                <= 1'b0;
      end else if (latch) begin
         idsel_from_ad17  <= capture_q[B_IDSEL];
         rom_remap_en     <= capture_q[B_REMAP] & capture_q[B_VGA_OFF];
         interrupt_pin_value <= capture_q[B_INT_ADV_N] ? INT_PIN_NONE : INT_PIN_ADV;
         vga_disabled     <= capture_q[B_VGA_OFF];
         multimedia_connector_mode     <= capture_q[B_CONN_N];
         legacy_feature_connector_mode <= ~capture_q[B_CONN_N];
         test_mode        <= capture_q[B_TEST];
         bar_prefetchable <= capture_q[B_PREFETCH];
         controller_disabled <= capture_q[B_OFF];
         idsel_enable     <= ~capture_q[B_OFF];
         bus_respond_en   <= ~capture_q[B_OFF];
         bus_drive_en     <= ~capture_q[B_OFF];
         chip_select_oe   <= {2{capture_q[B_CS_EN]}};
         bus_is_agp       <= agp_of(pkg_sync_q, capture_q[B_BUS_TYPE]);
         pll_vco_gain     <= vco_map(capture_q[B_VCO+1:B_VCO]);
         flash_bios_present <= capture_q[B_FLASH];
         sodimm_speed     <= capture_q[B_SODIMM+2:B_SODIMM];
         // PLL on AGP when normal, on PCI when alternate
         clock_from_pll   <= agp_of(pkg_sync_q, capture_q[B_BUS_TYPE]) ^ clk_sync_q;
         straps_latched   <= 1'b1;
      end
   end

   // Interrupt line is open drain and ignores the advertise strap
   assign irq_line_o = 1'b0;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_line_oe <= 1'b0;
      end else begin
         irq_line_oe <= irq_request & ~controller_disabled;
      end
   end

   // APB slave, zero wait states
   assign pready = 1'b1;
   assign hit    = (paddr == OFF_STATUS) || (paddr == OFF_SUBSYS) ||
                   (paddr == OFF_RAW_LO) || (paddr == OFF_RAW_HI);
   assign pslverr = psel & penable & ~hit;
   assign wr_en  = psel & penable & pwrite;

   // A firmware load of the memory type wins over the straps
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mt_written_q <= 1'b0;
         mt_wr_q      <= 3'h0;
      end else if (wr_en && paddr == OFF_STATUS) begin
         mt_written_q <= 1'b1;
         mt_wr_q      <= pwdata[2:0];
      end
   end

   // Type 111 stops memory access; other codes per encoding
   assign mem_type       = mt_written_q ? mt_wr_q : strap_q[B_MEMTYPE+2:B_MEMTYPE];
   assign mem_access_off = (mem_type == 3'h7);

   // Firmware write wins over a latch in the same cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         subsystem_vendor_identifier <= 16'h0000;
      end else if (wr_en && paddr == OFF_SUBSYS) begin
         subsystem_vendor_identifier <= pwdata[15:0];
      end else if (latch) begin
         subsystem_vendor_identifier <= capture_q[B_VEN+15:B_VEN];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         subsystem_device_identifier <= DEV_ID_RESET;
      end else if (wr_en && paddr == OFF_SUBSYS) begin
         subsystem_device_identifier <= pwdata[31:16];
      end else if (latch) begin
         subsystem_device_identifier[7:0] <= capture_q[B_DEV+7:B_DEV];
      end
   end

   always_comb begin
      status = 32'h0;
      status[S_MEMTYPE+2:S_MEMTYPE] = mt_written_q ? mt_wr_q : ~strap_q[B_MEMTYPE+2:B_MEMTYPE];
      status[S_MT_WRITTEN] = mt_written_q;
      status[S_VGA_OFF]    = vga_disabled;
      status[S_MM_MODE]    = multimedia_connector_mode;
      status[S_TEST]       = test_mode;
      status[S_PREFETCH]   = bar_prefetchable;
      status[S_OFF]        = controller_disabled;
      status[S_CS_EN]      = chip_select_oe[0];
      status[S_AGP]        = bus_is_agp;
      status[S_VCO+1:S_VCO] = pll_vco_gain;
      status[S_FLASH]      = flash_bios_present;
      status[S_SODIMM+2:S_SODIMM] = sodimm_speed;
      status[S_CLK_PLL]    = clock_from_pll;
      status[S_REMAP]      = rom_remap_en;
      status[S_IDSEL17]    = idsel_from_ad17;
      status[S_INT_ADV]    = interrupt_pin_value[0];
      status[S_LATCHED]    = straps_latched;
   end

   always_comb begin
      case (paddr)
         OFF_STATUS: rd_mux = status;
         OFF_SUBSYS: rd_mux = {subsystem_device_identifier, subsystem_vendor_identifier};
         OFF_RAW_LO: rd_mux = strap_q[31:0];
         OFF_RAW_HI: rd_mux = strap_q[63:32];
         default:    rd_mux = 32'h0;
      endcase
   end

   // Read data captured in the setup cycle so it is a flop output
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0 : rd_mux;
      end
   end

   a_idsel_latch: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      latch |=> idsel_from_ad17 == $past(capture_q[B_IDSEL]))
      else $error("Select source does not follow strap");

   a_conn_modes: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      multimedia_connector_mode != legacy_feature_connector_mode)
      else $error("Connector modes not exclusive");

   a_bus_type: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      straps_latched |-> bus_is_agp == (pkg_q ? !strap_q[B_BUS_TYPE] : strap_q[B_BUS_TYPE]))
      else $error("Bus type does not follow package and strap");

   a_clk_source: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      straps_latched |-> clock_from_pll == (bus_is_agp ^ clk_strap_q))
      else $error("Clock source does not follow strap and variant");

   a_remap_needs_vga: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      rom_remap_en |-> vga_disabled)
      else $error("ROM remap active with VGA enabled");

   a_intpin_value: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      latch |=> interrupt_pin_value == ($past(capture_q[B_INT_ADV_N]) ? 8'h00 : 8'h01))
      else $error("Interrupt pin value does not follow strap");

   a_irq_not_blocked: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (irq_request && !controller_disabled) |=> irq_line_oe)
      else $error("Interrupt request not driven");

   a_off_silence: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      controller_disabled |-> (!bus_respond_en && !bus_drive_en && !idsel_enable))
      else $error("Disabled controller still active on bus");

   a_memtype_inverse: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !mt_written_q |-> status[2:0] == ~mem_type)
      else $error("Strapped memory type not read back inverted");

   a_memtype_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (wr_en && paddr == OFF_STATUS) |=> (mem_type == $past(pwdata[2:0])) && status[2:0] == mem_type)
      else $error("Memory type write not applied");

   a_cs_tristate: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      latch |=> chip_select_oe == {2{$past(capture_q[B_CS_EN])}})
      else $error("Chip select enable mismatch");

   a_vco_map: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      latch |=> pll_vco_gain == {~$past(capture_q[B_VCO+1]), $past(capture_q[B_VCO])})
      else $error("VCO gain mapping wrong");

   a_hold_stable: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (phase_q == ST_HOLD && phase_d == ST_HOLD) |=> $stable(test_mode) && $stable(bus_is_agp))
      else $error("Settings changed while held");

   a_md_undriven: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !rst_sync_q [*2] |-> !memory_data_bus_oe)
      else $error("Memory data driven during bus reset");

endmodule : reset_strap_config

// >>> hw/strap_cfg_pkg.sv
package strap_cfg_pkg;
   // Strap bit positions on the memory data bus
   localparam int unsigned MD_W          = 64;
   localparam int unsigned B_IDSEL       = 62;
   localparam int unsigned B_REMAP       = 61;
   localparam int unsigned B_INT_ADV_N   = 59;
   localparam int unsigned B_VGA_OFF     = 58;
   localparam int unsigned B_CONN_N      = 57;
   localparam int unsigned B_TEST        = 55;
   localparam int unsigned B_PREFETCH    = 53;
   localparam int unsigned B_OFF         = 51;
   localparam int unsigned B_MEMTYPE     = 48;
   localparam int unsigned B_CS_EN       = 47;
   localparam int unsigned B_BUS_TYPE    = 40;
   localparam int unsigned B_VCO         = 38;
   localparam int unsigned B_FLASH       = 37;
   localparam int unsigned B_SODIMM      = 29;
   localparam int unsigned B_VEN         = 8;
   localparam int unsigned B_DEV         = 0;
   // Reserved positions 36:32 and 28:24 are masked off
   localparam logic [63:0] STRAP_MASK    = 64'hFFFF_FFE0_E0FF_FFFF;
   // Levels assumed before the first sampling
   localparam logic [63:0] STRAP_DEFAULT = 64'h0A00_8000_0000_0000;
   localparam logic [7:0]  INT_PIN_ADV   = 8'h01;
   localparam logic [7:0]  INT_PIN_NONE  = 8'h00;
   localparam logic [15:0] DEV_ID_RESET  = 16'h0000;
   // Register byte offsets
   localparam logic [11:0] OFF_STATUS    = 12'h000;
   localparam logic [11:0] OFF_SUBSYS    = 12'h004;
   localparam logic [11:0] OFF_RAW_LO    = 12'h008;
   localparam logic [11:0] OFF_RAW_HI    = 12'h00C;
   // Status register field positions
   localparam int unsigned S_MEMTYPE     = 0;
   localparam int unsigned S_MT_WRITTEN  = 3;
   localparam int unsigned S_VGA_OFF     = 4;
   localparam int unsigned S_MM_MODE     = 5;
   localparam int unsigned S_TEST        = 6;
   localparam int unsigned S_PREFETCH    = 7;
   localparam int unsigned S_OFF         = 8;
   localparam int unsigned S_CS_EN       = 9;
   localparam int unsigned S_AGP         = 10;
   localparam int unsigned S_VCO         = 11;
   localparam int unsigned S_FLASH       = 13;
   localparam int unsigned S_SODIMM      = 14;
   localparam int unsigned S_CLK_PLL     = 17;
   localparam int unsigned S_REMAP       = 18;
   localparam int unsigned S_IDSEL17     = 19;
   localparam int unsigned S_INT_ADV     = 20;
   localparam int unsigned S_LATCHED     = 21;

   typedef enum logic [2:0] {
      ST_WAIT   = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_HOLD   = 3'b100
   } phase_e;
endpackage : strap_cfg_pkg

// >>> verif/strap_resistor_model.sv
`timescale 1ns/100ps
module strap_resistor_model (
   input  wire logic        ref_clk,
   input  wire logic [63:0] strap_level,
   input  wire logic        memory_data_bus_oe,
   output logic      [63:0] memory_data_bus_i
);
   logic [63:0] drive_q = 64'h0;

   // Device data is not visible here, so a pattern that moves every cycle stands in for it
   always @(posedge ref_clk) begin
      drive_q <= drive_q + 64'h0123_4567_89AB_CDEF;
   end

   // Once the device lets go, only the pull resistors set the level
   assign memory_data_bus_i = memory_data_bus_oe ? (drive_q ^ ~strap_level) : strap_level;
endmodule : strap_resistor_model

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic [63:0] md;
      logic        clk;
      logic        bga;
      logic [2:0]  mt;
      logic [1:0]  gain;
      logic        agp;
      logic        pll;
   } row_s;

   localparam row_s ROWS [8] = '{
      '{64'h0000_0000_0000_0000, 1'b0, 1'b0, 3'h0, 2'h2, 1'b0, 1'b0},
      '{64'hFFFF_FFFF_FFFF_FFFF, 1'b1, 1'b1, 3'h7, 2'h1, 1'b0, 1'b1},
      '{64'h2001_0040_0012_345A, 1'b0, 1'b1, 3'h1, 2'h3, 1'b1, 1'b1},
      '{64'h0602_8180_ABCD_EF01, 1'b1, 1'b0, 3'h2, 2'h0, 1'b1, 1'b0},
      '{64'h08A4_0000_1F00_FF00, 1'b1, 1'b1, 3'h4, 2'h2, 1'b1, 1'b0},
      '{64'h000D_01C0_E000_0000, 1'b0, 1'b0, 3'h5, 2'h1, 1'b1, 1'b1},
      '{64'h6406_0140_0000_0001, 1'b0, 1'b1, 3'h6, 2'h3, 1'b0, 1'b0},
      '{64'h0003_8080_2000_0000, 1'b1, 1'b0, 3'h3, 2'h0, 1'b0, 1'b1}
   };

   logic        ref_clk, sys_rst, bus_reset_n, clock_source_strap_pin, package_is_bga, irq_request;
   logic        psel, penable, pwrite, pready, pslverr, memory_data_bus_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [63:0] strap_level, memory_data_bus_i;
   logic        idsel_from_ad17, idsel_enable, bus_respond_en, bus_drive_en, rom_remap_en, irq_line_oe;
   logic        vga_disabled, multimedia_connector_mode, legacy_feature_connector_mode, test_mode;
   logic        bar_prefetchable, controller_disabled, mem_access_off, bus_is_agp, flash_bios_present;
   logic        clock_from_pll, straps_latched, err, irq_line_o;
   logic [7:0]  interrupt_pin_value;
   logic [2:0]  mem_type, sodimm_speed;
   logic [1:0]  chip_select_oe, pll_vco_gain;
   logic [15:0] subsystem_vendor_identifier, subsystem_device_identifier;
   int          err_count = 0;
   int          n_tests = 0;
   int          cycles = 0;

   reset_strap_config dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_reset_n(bus_reset_n), .memory_data_bus_i(memory_data_bus_i),
      .clock_source_strap_pin(clock_source_strap_pin), .package_is_bga(package_is_bga), .irq_request(irq_request),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .memory_data_bus_oe(memory_data_bus_oe),
      .idsel_from_ad17(idsel_from_ad17), .idsel_enable(idsel_enable), .bus_respond_en(bus_respond_en),
      .bus_drive_en(bus_drive_en), .rom_remap_en(rom_remap_en), .interrupt_pin_value(interrupt_pin_value),
      .irq_line_o(irq_line_o), .irq_line_oe(irq_line_oe), .vga_disabled(vga_disabled),
      .multimedia_connector_mode(multimedia_connector_mode),
      .legacy_feature_connector_mode(legacy_feature_connector_mode), .test_mode(test_mode),
      .bar_prefetchable(bar_prefetchable), .controller_disabled(controller_disabled), .mem_type(mem_type),
      .mem_access_off(mem_access_off), .chip_select_oe(chip_select_oe), .bus_is_agp(bus_is_agp),
      .pll_vco_gain(pll_vco_gain), .flash_bios_present(flash_bios_present), .sodimm_speed(sodimm_speed),
      .subsystem_vendor_identifier(subsystem_vendor_identifier),
      .subsystem_device_identifier(subsystem_device_identifier), .clock_from_pll(clock_from_pll),
      .straps_latched(straps_latched)
   );

   strap_resistor_model u_straps (
      .ref_clk(ref_clk), .strap_level(strap_level), .memory_data_bus_oe(memory_data_bus_oe),
      .memory_data_bus_i(memory_data_bus_i)
   );

   always #10 ref_clk = ~ref_clk;

   task automatic check_value(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check_value

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         err_count++;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   task automatic strap_load(input logic [63:0] md, input logic clk_strap, input logic bga);
      int k;
      @(posedge ref_clk);
      strap_level            <= md;
      clock_source_strap_pin <= clk_strap;
      package_is_bga         <= bga;
      bus_reset_n            <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      check_value("md_oe_sampling", memory_data_bus_oe, 1'b0);
      @(posedge ref_clk);
      bus_reset_n <= 1'b1;
      k = 0;
      while (memory_data_bus_oe !== 1'b1 && k < 12) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      check_value("md_oe_held", memory_data_bus_oe, 1'b1);
      // Strap levels that move after release must not reach the outputs
      @(posedge ref_clk);
      strap_level            <= ~md;
      clock_source_strap_pin <= ~clk_strap;
      repeat (5) @(posedge ref_clk);
      #1;
   endtask : strap_load

   task automatic check_row(input row_s r);
      logic [63:0] md;
      md = r.md;
      check_value("idsel", idsel_from_ad17, md[62]);
      check_value("remap", rom_remap_en, md[61] & md[58]);
      check_value("int_pin", interrupt_pin_value, md[59] ? 8'h00 : 8'h01);
      check_value("irq_oe", {irq_line_oe, irq_line_o}, {!md[51], 1'b0});
      check_value("latched", straps_latched, 1'b1);
      check_value("vga", vga_disabled, md[58]);
      check_value("conn", {multimedia_connector_mode, legacy_feature_connector_mode}, {md[57], ~md[57]});
      check_value("test", test_mode, md[55]);
      check_value("prefetch", bar_prefetchable, md[53]);
      check_value("off", {controller_disabled, idsel_enable, bus_respond_en, bus_drive_en}, {md[51], {3{~md[51]}}});
      check_value("mem_type", {mem_access_off, mem_type}, {r.mt == 3'h7, r.mt});
      apb(1'b0, 12'h000, 32'h0);
      check_value("status_mt", rd[2:0], 3'(~r.mt));
      check_value("cs_oe", chip_select_oe, {2{md[47]}});
      check_value("agp", bus_is_agp, r.agp);
      check_value("gain", pll_vco_gain, r.gain);
      check_value("flash", flash_bios_present, md[37]);
      check_value("sodimm", sodimm_speed, md[31:29]);
      check_value("ids", {subsystem_device_identifier, subsystem_vendor_identifier}, {8'h00, md[7:0], md[23:8]});
      check_value("pll", clock_from_pll, r.pll);
      apb(1'b0, 12'h008, 32'h0);
      check_value("raw_lo", rd, md[31:0] & 32'hE0FF_FFFF);
      apb(1'b0, 12'h00C, 32'h0);
      check_value("raw_hi", rd, md[63:32] & 32'hFFFF_FFE0);
   endtask : check_row

   task print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      {ref_clk, psel, penable, pwrite, clock_source_strap_pin, package_is_bga} = 6'h00;
      {sys_rst, bus_reset_n, irq_request} = 3'h7;
      paddr = 12'h000;
      pwdata = 32'h0;
      strap_level = 64'h0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         strap_load(ROWS[i].md, ROWS[i].clk, ROWS[i].bga);
         check_row(ROWS[i]);
         $display("strap row %0d done", i);
      end
      apb(1'b1, 12'h004, 32'hBEEF_1234);
      check_value("fw_ids", {subsystem_device_identifier, subsystem_vendor_identifier}, 32'hBEEF_1234);
      strap_load(ROWS[2].md, 1'b0, 1'b1);
      check_value("reload_ids", {subsystem_device_identifier, subsystem_vendor_identifier}, 32'hBE5A_1234);
      apb(1'b1, 12'h000, 32'hFFFF_FFF5);
      check_value("fw_mem_type", mem_type, 3'h5);
      check_value("ro_test", test_mode, 1'b0);
      apb(1'b0, 12'h000, 32'h0);
      check_value("fw_status_mt", rd[2:0], 3'h5);
      apb(1'b1, 12'h010, 32'h0);
      check_value("unmapped", {err, mem_type}, 4'hD);
      $display("firmware test done");
      @(posedge ref_clk);
      irq_request <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check_value("irq_idle", irq_line_oe, 1'b0);
      $display("interrupt test done");
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      check_value("rst_defaults", {interrupt_pin_value, chip_select_oe, pll_vco_gain}, 12'h00E);
      check_value("rst_latch", {memory_data_bus_oe, straps_latched}, 2'b00);
      $display("reset test done");
      print_verdict();
   end
endmodule : tb_top
